// [src/vim_pkg.sv]
// vim_pkg: shared constants for the vectored interrupt map
// assumes a 16-bit vector space at the top of memory, 32-bit apb data
package vim_pkg;
  // number of ranked slots; slot k sits at vector top - 2k
  localparam int unsigned VIM_SLOTS = 64;
  localparam logic [15:0] VIM_VEC_TOP = 16'hfffe;
  localparam logic [15:0] VIM_VEC_STEP = 16'h0002;
  localparam logic [15:0] VIM_VEC_BASE = 16'hff80;
  // slot indices of the documented sources
  localparam int unsigned VIM_S_RESET = 0;
  localparam int unsigned VIM_S_CLKMON = 1;
  localparam int unsigned VIM_S_WDOG = 2;
  localparam int unsigned VIM_S_TRAP = 3;
  localparam int unsigned VIM_S_SWTRAP = 4;
  localparam int unsigned VIM_S_XPIN = 5;
  localparam int unsigned VIM_S_FIRST_I = 6;
  localparam int unsigned VIM_S_TCH0 = 8;
  localparam int unsigned VIM_S_TOVF = 16;
  localparam int unsigned VIM_S_ACCA_OVF = 17;
  localparam int unsigned VIM_S_ACCA_EDGE = 18;
  localparam int unsigned VIM_S_SER0 = 20;
  localparam int unsigned VIM_S_SER1 = 21;
  localparam int unsigned VIM_S_PORTJ = 24;
  localparam int unsigned VIM_S_MODC = 26;
  localparam int unsigned VIM_S_ACCB_OVF = 27;
  localparam int unsigned VIM_S_NET_FIFO = 44;
  localparam int unsigned VIM_S_NET_GEN = 47;
  // reserved slots: ffbc, ff98-ff9f, ff80-ff8b
  localparam logic [63:0] VIM_RESERVED = 64'hfc0f_0002_0000_0000;
  // apb register byte offsets
  localparam logic [11:0] VIM_A_ELEV = 12'h000;
  localparam logic [11:0] VIM_A_TIMER_EN = 12'h004;
  localparam logic [11:0] VIM_A_MISC_EN = 12'h008;
  localparam logic [11:0] VIM_A_SER_EN = 12'h00c;
  localparam logic [11:0] VIM_A_NET_EN = 12'h010;
  localparam logic [11:0] VIM_A_BUF_EN = 12'h014;
  localparam logic [11:0] VIM_A_VECTOR = 12'h018;
  localparam logic [11:0] VIM_A_IRQ_STAT = 12'h01c;
  localparam logic [11:0] VIM_A_IRQ_MASK = 12'h020;
  // reset values
  localparam logic [7:0] VIM_ELEV_RST = 8'hf2;
  localparam logic [31:0] VIM_ZERO = 32'h0000_0000;
  // misc enable bit positions
  localparam int unsigned VIM_M_PIN = 0;
  localparam int unsigned VIM_M_TICK = 1;
  localparam int unsigned VIM_M_TOVF = 2;
  localparam int unsigned VIM_M_ACCA_OVF = 3;
  localparam int unsigned VIM_M_ACCA_EDGE = 4;
  localparam int unsigned VIM_M_MODC = 5;
  localparam int unsigned VIM_M_ACCB_OVF = 6;
  localparam int unsigned VIM_M_CLKMON = 7;
  localparam int unsigned VIM_M_FCLKMON = 8;
  localparam int unsigned VIM_M_SYNC = 9;
  localparam int unsigned VIM_M_FIFO = 10;
  localparam int unsigned VIM_M_SLMM = 11;
  localparam int unsigned VIM_MISC_W = 12;
  // port j pins that may interrupt
  localparam logic [7:0] VIM_PJ_LEGAL = 8'hc3;
endpackage

// [src/vim_sel_if.sv]
// vim_sel_if: carries ranked requests to the priority encoder and its answer back
// assumes one pclk domain
`timescale 1ns/1ps
interface vim_sel_if;
  logic [63:0] req;
  logic [5:0] elev_slot;
  logic elev_ok;
  logic hit;
  logic [5:0] slot;
  modport ctl (output req, output elev_slot, output elev_ok, input hit, input slot);
  modport enc (input req, input elev_slot, input elev_ok, output hit, output slot);
endinterface

// [src/vim_prio_enc.sv]
// vim_prio_enc: finds the highest-ranked pending slot, elevated slot wins among i-masked
// assumes req already gated by masks, enables and reserved map
`timescale 1ns/1ps
module vim_prio_enc
  import vim_pkg::*;
(
  // selection channel
  vim_sel_if.enc sel
);
  // lowest index is top rank; elevation only beats i-masked slots
  always_comb begin
    sel.hit = 1'b0;
    sel.slot = 6'h00;
    for (int k = VIM_SLOTS - 1; k >= 0; k--) begin
      if (sel.req[k]) begin
        sel.hit = 1'b1;
        sel.slot = 6'(k);
      end
    end
    if (sel.elev_ok && sel.req[sel.elev_slot] && sel.slot >= 6'(VIM_S_FIRST_I)) begin
      sel.slot = sel.elev_slot;
    end
  end
endmodule

// [src/vim_top.sv]
// vim_top: vector map with local enables, ccr masking, elevation and apb registers
// assumes event inputs are pclk-synchronous levels from peripherals; ccr bits from core
`timescale 1ns/1ps
module vim_top
  import vim_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic ccr_x,
  input wire logic ccr_i,
  input wire logic rst_por,
  input wire logic rst_clkmon,
  input wire logic rst_wdog,
  input wire logic trap_opcode,
  input wire logic software_trap,
  output logic vec_valid,
  output logic [15:0] vec_addr,
  // peripheral events
  input wire logic nonmaskable_pin_request,
  input wire logic pin_request,
  input wire logic tick_event,
  input wire logic [7:0] timer_ch_event,
  input wire logic timer_ovf_event,
  input wire logic acca_ovf_event,
  input wire logic acca_edge_event,
  input wire logic modc_event,
  input wire logic accb_ovf_event,
  input wire logic [7:0] port_j_event,
  input wire logic [3:0] ser0_event,
  input wire logic [3:0] ser1_event,
  input wire logic net_sync_event,
  input wire logic net_fifo_nonempty,
  input wire logic [15:0] net_buf_event,
  input wire logic [6:0] net_gen_event,
  input wire logic net_slmm_event,
  // interrupt out
  output logic irq
);
  // control registers
  logic [7:0] elev_q, elev_d;
  logic [7:0] timer_en_q, timer_en_d;
  logic [VIM_MISC_W-1:0] misc_en_q, misc_en_d;
  logic [15:0] ser_en_q, ser_en_d;
  logic [14:0] net_en_q, net_en_d;
  logic [15:0] buf_en_q, buf_en_d;
  logic [1:0] ist_q, ist_d;
  logic [1:0] imask_q, imask_d;
  logic [15:0] vec_q, vec_d;
  logic vval_q, vval_d;
  logic [31:0] rdata_q, rdata_d;
  logic [63:0] raw_req;
  logic [63:0] gated;
  logic [15:0] ev_vec;
  logic [5:0] ev_slot;
  logic ev_ok;
  logic wr_en;
  logic rd_en;
  logic mapped;
  vim_sel_if sel ();

  // slot to vector address; byte value to slot when legal
  function automatic logic [15:0] slot_vec(input logic [5:0] s);
    slot_vec = VIM_VEC_TOP - {9'h000, s, 1'b0};
  endfunction
  function automatic logic [5:0] byte_slot(input logic [7:0] b);
    logic [15:0] off;
    off = VIM_VEC_TOP - {8'hff, b};
    byte_slot = off[6:1];
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr <= VIM_A_IRQ_MASK) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !mapped;

  // per-source request before ccr masking
  always_comb begin
    raw_req = 64'h0;
    raw_req[VIM_S_RESET] = rst_por;
    raw_req[VIM_S_CLKMON] = rst_clkmon
      && (misc_en_q[VIM_M_CLKMON] || misc_en_q[VIM_M_FCLKMON]);
    raw_req[VIM_S_WDOG] = rst_wdog;
    raw_req[VIM_S_TRAP] = trap_opcode;
    raw_req[VIM_S_SWTRAP] = software_trap;
    raw_req[VIM_S_XPIN] = nonmaskable_pin_request
      || (net_sync_event && misc_en_q[VIM_M_SYNC]);
    raw_req[VIM_S_FIRST_I] = pin_request && misc_en_q[VIM_M_PIN];
    raw_req[VIM_S_FIRST_I + 1] = tick_event && misc_en_q[VIM_M_TICK];
    for (int c = 0; c < 8; c++) begin
      raw_req[VIM_S_TCH0 + c] = timer_ch_event[c] && timer_en_q[c];
    end
    raw_req[VIM_S_TOVF] = timer_ovf_event && misc_en_q[VIM_M_TOVF];
    raw_req[VIM_S_ACCA_OVF] = acca_ovf_event && misc_en_q[VIM_M_ACCA_OVF];
    raw_req[VIM_S_ACCA_EDGE] = acca_edge_event && misc_en_q[VIM_M_ACCA_EDGE];
    raw_req[VIM_S_SER0] = |(ser0_event & ser_en_q[3:0]);
    raw_req[VIM_S_SER1] = |(ser1_event & ser_en_q[11:8]);
    raw_req[VIM_S_PORTJ] = |(port_j_event & ser_en_q[15:8] & VIM_PJ_LEGAL);
    raw_req[VIM_S_MODC] = modc_event && misc_en_q[VIM_M_MODC];
    raw_req[VIM_S_ACCB_OVF] = accb_ovf_event && misc_en_q[VIM_M_ACCB_OVF];
    raw_req[VIM_S_NET_FIFO] = net_fifo_nonempty && misc_en_q[VIM_M_FIFO];
    raw_req[VIM_S_NET_GEN] = |(net_buf_event & buf_en_q)
      || |(net_gen_event & net_en_q[6:0])
      || (net_slmm_event && misc_en_q[VIM_M_SLMM]);
  end

  // ccr masking and reserved slots removed before ranking
  always_comb begin
    gated = raw_req & ~VIM_RESERVED;
    if (ccr_x) begin
      gated[VIM_S_XPIN] = 1'b0;
    end
    if (ccr_i) begin
      gated[VIM_SLOTS-1:VIM_S_FIRST_I] = '0;
    end
  end

  assign ev_slot = byte_slot(elev_q);
  // bytes below 80 would wrap into the slot range, so only the top half is legal
  assign ev_ok = (elev_q[0] == 1'b0) && (elev_q[7] == 1'b1)
    && (ev_slot >= 6'(VIM_S_FIRST_I))
    && !VIM_RESERVED[ev_slot];
  assign sel.req = gated;
  assign sel.elev_slot = ev_slot;
  assign sel.elev_ok = ev_ok;
  vim_prio_enc u_enc (
    .sel(sel)
  );
  assign ev_vec = slot_vec(sel.slot);

  // register writes, vector capture, sticky status and read data
  always_comb begin
    elev_d = elev_q;
    timer_en_d = timer_en_q;
    misc_en_d = misc_en_q;
    ser_en_d = ser_en_q;
    net_en_d = net_en_q;
    buf_en_d = buf_en_q;
    imask_d = imask_q;
    ist_d = ist_q;
    vec_d = sel.hit ? ev_vec : vec_q;
    vval_d = sel.hit;
    rdata_d = VIM_ZERO;
    if (wr_en) begin
      unique case (paddr)
        VIM_A_ELEV: elev_d = pwdata[7:0];
        VIM_A_TIMER_EN: timer_en_d = pwdata[7:0];
        VIM_A_MISC_EN: misc_en_d = pwdata[VIM_MISC_W-1:0];
        VIM_A_SER_EN: ser_en_d = pwdata[15:0];
        VIM_A_NET_EN: net_en_d = pwdata[14:0];
        VIM_A_BUF_EN: buf_en_d = pwdata[15:0];
        VIM_A_IRQ_MASK: imask_d = pwdata[1:0];
        default: ;
      endcase
    end
    if (rd_en) begin
      unique case (paddr)
        VIM_A_ELEV: rdata_d = {24'h0, elev_q};
        VIM_A_TIMER_EN: rdata_d = {24'h0, timer_en_q};
        VIM_A_MISC_EN: rdata_d = {20'h0, misc_en_q};
        VIM_A_SER_EN: rdata_d = {16'h0, ser_en_q};
        VIM_A_NET_EN: rdata_d = {17'h0, net_en_q};
        VIM_A_BUF_EN: rdata_d = {16'h0, buf_en_q};
        VIM_A_VECTOR: rdata_d = {15'h0, vval_q, vec_q};
        VIM_A_IRQ_STAT: begin
          rdata_d = {30'h0, ist_q};
          ist_d = 2'b00; // read clears
        end
        VIM_A_IRQ_MASK: rdata_d = {30'h0, imask_q};
        default: rdata_d = VIM_ZERO;
      endcase
    end
    // set beats read clear: bit0 new vector, bit1 elevated source served
    if (sel.hit && (!vval_q || ev_vec != vec_q)) begin
      ist_d[0] = 1'b1;
    end
    if (sel.hit && ev_ok && sel.slot == ev_slot) begin
      ist_d[1] = 1'b1;
    end
  end

  // registers; all controls to defaults on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elev_q <= VIM_ELEV_RST;
      timer_en_q <= '0;
      misc_en_q <= '0;
      ser_en_q <= '0;
      net_en_q <= '0;
      buf_en_q <= '0;
      imask_q <= '0;
      ist_q <= '0;
      vec_q <= VIM_VEC_TOP;
      vval_q <= 1'b0;
      rdata_q <= VIM_ZERO;
    end else begin
      elev_q <= elev_d;
      timer_en_q <= timer_en_d;
      misc_en_q <= misc_en_d;
      ser_en_q <= ser_en_d;
      net_en_q <= net_en_d;
      buf_en_q <= buf_en_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      vec_q <= vec_d;
      vval_q <= vval_d;
      rdata_q <= rdata_d;
    end
  end

  // read data comes straight from the registers during the access; rdata_q holds the last word for one cycle, then zero
  assign prdata = rd_en ? rdata_d : rdata_q;
  assign vec_valid = vval_q;
  assign vec_addr = vec_q;
  assign irq = |(ist_q & imask_q);

  // checks; vector numbers are written out so that a wrong slot index shows up
  reset_vec_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    rst_por |=> vec_valid && vec_addr == 16'hfffe) else $error("reset vector wrong");
  xmask_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    ccr_x && !(|raw_req[VIM_S_XPIN-1:0]) && !(|gated[VIM_SLOTS-1:VIM_S_FIRST_I])
    |=> !vec_valid) else $error("x mask leak");
  imask_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    ccr_i && !(|raw_req[VIM_S_FIRST_I-1:0]) |=> !vec_valid) else $error("i mask leak");
  reserved_never_a: assert property (@(posedge pclk) disable iff (!presetn)
    vec_valid |-> !(vec_addr == 16'hffbc || (vec_addr >= 16'hff98 && vec_addr <= 16'hff9e)
    || vec_addr < 16'hff8c)) else $error("reserved vector produced");
  timer_ch_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(|raw_req[VIM_S_TCH0-1:0]) && !ccr_i && timer_ch_event[0] && timer_en_q[0]
    && !(ev_ok && gated[ev_slot]) |=> vec_addr == 16'hffee) else $error("timer ch0 vector");
  elev_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(|gated[VIM_S_FIRST_I-1:0]) && ev_ok && gated[ev_slot]
    |=> vec_addr == {8'hff, $past(elev_q)}) else $error("elevation ignored");
  top_rank_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && !(ev_ok && gated[ev_slot]) |-> gated[sel.slot]
    && (sel.slot == 6'h00 || !(|(gated & ((64'h1 << sel.slot) - 64'h1)))))
    else $error("not top rank");
  hit_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|gated) |=> vec_valid) else $error("pending request not presented");
  ovf_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    !misc_en_q[VIM_M_TOVF] |-> !raw_req[VIM_S_TOVF]) else $error("overflow enable ignored");
  sync_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !misc_en_q[VIM_M_SYNC] && !nonmaskable_pin_request |-> !raw_req[VIM_S_XPIN])
    else $error("sync enable ignored");
  portj_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (port_j_event & VIM_PJ_LEGAL) == 8'h00 |-> !raw_req[VIM_S_PORTJ])
    else $error("port j bad pin");
  status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && !vval_q |=> ist_q[0]) else $error("new vector status lost");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(vec_valid) && imask_q[0] |-> irq) else $error("irq level");
  // each source checked below lands on its own vector; clock monitor, trap, software trap and tick are not covered here
  wdog_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_WDOG) |=> vec_addr == 16'hfffa)
    else $error("watchdog vector");
  xpin_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_XPIN) |=> vec_addr == 16'hfff4)
    else $error("x pin vector");
  pin_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_FIRST_I) |=> vec_addr == 16'hfff2)
    else $error("pin vector");
  tch7_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_TCH0 + 7) |=> vec_addr == 16'hffe0)
    else $error("timer ch7 vector");
  tovf_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_TOVF) |=> vec_addr == 16'hffde)
    else $error("timer overflow vector");
  acca_ovf_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_ACCA_OVF) |=> vec_addr == 16'hffdc)
    else $error("accumulator a overflow vector");
  acca_edge_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_ACCA_EDGE) |=> vec_addr == 16'hffda)
    else $error("accumulator a edge vector");
  modc_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_MODC) |=> vec_addr == 16'hffca)
    else $error("modulus vector");
  accb_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_ACCB_OVF) |=> vec_addr == 16'hffc8)
    else $error("accumulator b vector");
  ser0_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_SER0) |=> vec_addr == 16'hffd6)
    else $error("serial 0 vector");
  ser1_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_SER1) |=> vec_addr == 16'hffd4)
    else $error("serial 1 vector");
  portj_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_PORTJ) |=> vec_addr == 16'hffce)
    else $error("port j vector");
  netgen_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_NET_GEN) |=> vec_addr == 16'hffa0)
    else $error("network general vector");
  fifo_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel.hit && sel.slot == 6'(VIM_S_NET_FIFO) |=> vec_addr == 16'hffa6)
    else $error("network fifo vector");
endmodule

// [tb/vim_core_model.sv]
// vim_core_model: core-side partner that fetches whatever vector is presented
// assumes vec_valid and vec_addr are registered on pclk
`timescale 1ns/1ps
module vim_core_model
  import vim_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // vector from the map
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr,
  // last fetched vector
  output logic [15:0] fetched_q
);
  logic [15:0] fetched_d;
  // the core only fetches while a request stands; a held stale vector is ignored
  always_comb begin
    fetched_d = vec_valid ? vec_addr : fetched_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetched_q <= VIM_VEC_TOP;
    end else begin
      fetched_q <= fetched_d;
    end
  end
endmodule

// [tb/testbench.sv]
// testbench: self-checking bench for the vectored interrupt map
// assumes vim_top with its apb registers, and the core model beside it
`timescale 1ns/1ps
module testbench;
  import vim_pkg::*;
  typedef struct packed {
    logic ccr_x, ccr_i, rst_por, rst_clkmon, rst_wdog, trap_opcode, software_trap;
    logic nonmaskable_pin_request, pin_request, tick_event, timer_ovf_event;
    logic acca_ovf_event, acca_edge_event, modc_event, accb_ovf_event;
    logic net_sync_event, net_fifo_nonempty, net_slmm_event;
    logic [7:0] timer_ch_event, port_j_event;
    logic [3:0] ser0_event, ser1_event;
    logic [15:0] net_buf_event;
    logic [6:0] net_gen_event;
  } vim_ev_t;
  localparam int SL [6] = '{VIM_S_TOVF, VIM_S_ACCA_OVF, VIM_S_ACCA_EDGE, VIM_S_MODC,
    VIM_S_ACCB_OVF, VIM_S_NET_FIFO};
  logic pclk, psel, penable, pwrite, pready, pslverr, vec_valid, irq, err;
  logic presetn = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] vec_addr, fetched_q;
  vim_ev_t ev = '0;
  int errors = 0;
  int n_checks = 0;

  vim_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .vec_valid, .vec_addr, .irq, .ccr_x(ev.ccr_x), .ccr_i(ev.ccr_i),
    .rst_por(ev.rst_por), .rst_clkmon(ev.rst_clkmon), .rst_wdog(ev.rst_wdog),
    .trap_opcode(ev.trap_opcode), .software_trap(ev.software_trap),
    .nonmaskable_pin_request(ev.nonmaskable_pin_request), .pin_request(ev.pin_request),
    .tick_event(ev.tick_event), .timer_ch_event(ev.timer_ch_event),
    .timer_ovf_event(ev.timer_ovf_event), .acca_ovf_event(ev.acca_ovf_event),
    .acca_edge_event(ev.acca_edge_event), .modc_event(ev.modc_event),
    .accb_ovf_event(ev.accb_ovf_event), .port_j_event(ev.port_j_event),
    .ser0_event(ev.ser0_event), .ser1_event(ev.ser1_event), .net_sync_event(ev.net_sync_event),
    .net_fifo_nonempty(ev.net_fifo_nonempty), .net_buf_event(ev.net_buf_event),
    .net_gen_event(ev.net_gen_event), .net_slmm_event(ev.net_slmm_event));
  vim_core_model core (.pclk, .presetn, .vec_valid, .vec_addr, .fetched_q);

  // 40 mhz bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  // expected vector of a ranked slot, worked out from the top of the table
  function automatic logic [15:0] vo(input int s);
    return VIM_VEC_TOP - VIM_VEC_STEP * 16'(s);
  endfunction

  // a held vec_addr means nothing without vec_valid, so it is only compared when valid
  task chk_vec(input logic v, input int s);
    chk("vec_valid", {31'h0, v}, {31'h0, vec_valid});
    if (v) begin
      chk("vec_addr", {16'h0, vo(s)}, {16'h0, vec_addr});
      chk("fetched", {16'h0, vo(s)}, {16'h0, fetched_q});
    end
  endtask

  // new request levels land after an edge; vector and fetch settle within four edges
  task put(input vim_ev_t v);
    @(posedge pclk);
    ev <= v;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  // apb transfer: request held until pready is sampled high, then released
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task t_reset;
    apb(0, VIM_A_ELEV, 0);
    chk("elev", {24'h0, VIM_ELEV_RST}, r);
    apb(0, VIM_A_MISC_EN, 0);
    chk("misc_en", VIM_ZERO, r);
    apb(0, VIM_A_VECTOR, 0);
    chk("vector_reg", {16'h0, VIM_VEC_TOP}, r);
    chk("irq", 32'h0, {31'h0, irq});
    chk_vec(0, 0);
  endtask

  task t_resets;
    put('{rst_por:1, rst_clkmon:1, rst_wdog:1, software_trap:1, default:0});
    chk_vec(1, VIM_S_RESET);
    put('{rst_clkmon:1, rst_wdog:1, software_trap:1, default:0});
    chk_vec(1, VIM_S_WDOG);
    apb(1, VIM_A_MISC_EN, 32'h1 << VIM_M_CLKMON);
    put('{rst_clkmon:1, software_trap:1, default:0});
    chk_vec(1, VIM_S_CLKMON);
    apb(1, VIM_A_MISC_EN, 32'h1 << VIM_M_FCLKMON);
    put('{rst_clkmon:1, software_trap:1, default:0});
    chk_vec(1, VIM_S_CLKMON);
    put('{ccr_x:1, ccr_i:1, trap_opcode:1, software_trap:1, default:0});
    chk_vec(1, VIM_S_TRAP);
    put('{ccr_x:1, ccr_i:1, software_trap:1, default:0});
    chk_vec(1, VIM_S_SWTRAP);
  endtask

  task t_xmask;
    put('{ccr_x:1, nonmaskable_pin_request:1, default:0});
    chk_vec(0, 0);
    put('{nonmaskable_pin_request:1, default:0});
    chk_vec(1, VIM_S_XPIN);
    put('{net_sync_event:1, default:0});
    chk_vec(0, 0);
    apb(1, VIM_A_MISC_EN, 32'h1 << VIM_M_SYNC);
    put('{net_sync_event:1, default:0});
    chk_vec(1, VIM_S_XPIN);
  endtask

  task t_elev;
    apb(1, VIM_A_MISC_EN, 32'h3);
    put('{ccr_i:1, pin_request:1, tick_event:1, default:0});
    chk_vec(0, 0);
    put('{pin_request:1, tick_event:1, default:0});
    chk_vec(1, VIM_S_FIRST_I);
    apb(1, VIM_A_ELEV, 32'hf0);
    put('{pin_request:1, tick_event:1, default:0});
    chk_vec(1, VIM_S_FIRST_I + 1);
    put('{pin_request:1, tick_event:1, nonmaskable_pin_request:1, default:0});
    chk_vec(1, VIM_S_XPIN);
    apb(1, VIM_A_ELEV, 32'hf2);
    apb(1, VIM_A_TIMER_EN, 32'hff);
    // higher channels stay pending so each step also proves the descending rank
    for (int c = 0; c < 8; c++) begin
      put('{timer_ch_event:8'hff << c, default:0});
      chk_vec(1, VIM_S_TCH0 + c);
    end
    apb(1, VIM_A_TIMER_EN, 32'h7f);
    put('{timer_ch_event:8'h80, default:0});
    chk_vec(0, 0);
  endtask

  task t_misc;
    apb(1, VIM_A_MISC_EN, 32'h47c);
    for (int k = 0; k < 6; k++) begin
      case (k)
        0: put('{timer_ovf_event:1, default:0});
        1: put('{acca_ovf_event:1, default:0});
        2: put('{acca_edge_event:1, default:0});
        3: put('{modc_event:1, default:0});
        4: put('{accb_ovf_event:1, default:0});
        default: put('{net_fifo_nonempty:1, default:0});
      endcase
      chk_vec(1, SL[k]);
    end
    apb(1, VIM_A_MISC_EN, 32'h478);
    put('{timer_ovf_event:1, default:0});
    chk_vec(0, 0);
  endtask

  task t_serial;
    apb(1, VIM_A_SER_EN, 32'h0804);
    put('{ser0_event:4'h2, default:0});
    chk_vec(0, 0);
    put('{ser0_event:4'h4, default:0});
    chk_vec(1, VIM_S_SER0);
    put('{ser1_event:4'h8, default:0});
    chk_vec(1, VIM_S_SER1);
    apb(1, VIM_A_SER_EN, 32'h8400);
    put('{port_j_event:8'h04, default:0});
    chk_vec(0, 0);
    put('{port_j_event:8'h84, default:0});
    chk_vec(1, VIM_S_PORTJ);
  endtask

  task t_net;
    apb(1, VIM_A_BUF_EN, 32'h20);
    put('{net_buf_event:16'h0010, default:0});
    chk_vec(0, 0);
    put('{net_buf_event:16'h0020, default:0});
    chk_vec(1, VIM_S_NET_GEN);
    apb(1, VIM_A_NET_EN, 32'h40);
    put('{net_gen_event:7'h40, default:0});
    chk_vec(1, VIM_S_NET_GEN);
    apb(1, VIM_A_MISC_EN, 32'h1 << VIM_M_SLMM);
    put('{net_slmm_event:1, default:0});
    chk_vec(1, VIM_S_NET_GEN);
  endtask

  // raise, read-clear and mask the new-vector interrupt, then hit an unmapped word
  task t_irq;
    put('0);
    apb(0, VIM_A_IRQ_STAT, 0);
    chk("irq_stat", 32'h3, r);
    apb(1, VIM_A_IRQ_MASK, 32'h1);
    put('{software_trap:1, default:0});
    chk("irq", 32'h1, {31'h0, irq});
    put('0);
    apb(0, VIM_A_IRQ_STAT, 0);
    chk("irq_stat", 32'h1, r & 32'h1);
    put('0);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1, VIM_A_IRQ_MASK, 32'h0);
    put('{software_trap:1, default:0});
    chk("irq", 32'h0, {31'h0, irq});
    apb(0, 12'h040, 0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("rd_unmapped", 32'h0, r);
  endtask

  // a second reset in mid-run must bring the elevation and the misc enables home
  task t_rst2;
    apb(1, VIM_A_ELEV, 32'hf0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk_vec(0, 0);
    presetn <= 1'b1;
    apb(0, VIM_A_ELEV, 0);
    chk("elev", {24'h0, VIM_ELEV_RST}, r);
    apb(0, VIM_A_MISC_EN, 0);
    chk("misc_en", VIM_ZERO, r);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_resets;
    t_xmask;
    t_elev;
    t_misc;
    t_serial;
    t_net;
    t_irq;
    t_rst2;
    results;
  end

  // the whole run needs about 310 cycles; this cuts a hang short
  initial begin
    #500000;
    errors++;
    results;
  end
endmodule
